// ===== cit_pkg.sv
/*
 * Shared constants and types of the instruction timing decoder.
 * Assumes a single 20 MHz system clock and opcodes in the standard
 * 8-bit instruction set encoding.
 */
package cit_pkg;

	// Clock figures
	localparam int CLOCK_PERIOD_NS = 50; // System clock period
	localparam int MAX_CLOCK_MHZ = 25; // Fastest rated system clock
	localparam int PEAK_MIPS = 25; // One instruction per clock at top rate

	// Instruction set figures
	localparam int INSTR_TOTAL = 109; // Distinct instructions decoded
	localparam int INSTR_ONE_CYCLE = 26; // Instructions needing one clock
	localparam int INSTR_TWO_CYCLE = 50; // Instructions needing two clocks

	// Widths
	localparam int OPCODE_W = 8; // Opcode byte
	localparam int LEN_W = 2; // Program bytes of one instruction
	localparam int CYC_W = 4; // Clock count of one instruction
	localparam int ADDR_W = 16; // Memory address

	// Program byte lengths
	localparam logic [LEN_W-1:0] LEN_1 = 2'h1;
	localparam logic [LEN_W-1:0] LEN_2 = 2'h2;
	localparam logic [LEN_W-1:0] LEN_3 = 2'h3;

	// Clock counts
	localparam logic [CYC_W-1:0] CYC_1 = 4'h1;
	localparam logic [CYC_W-1:0] CYC_2 = 4'h2;
	localparam logic [CYC_W-1:0] CYC_3 = 4'h3;
	localparam logic [CYC_W-1:0] CYC_4 = 4'h4;
	localparam logic [CYC_W-1:0] CYC_5 = 4'h5;
	localparam logic [CYC_W-1:0] CYC_MAX = 4'h8; // Longest instruction, the divide

	// Default size of the on-chip expansion data RAM in bytes
	localparam int EXPANSION_DATA_RAM_BYTES = 4096;

	// Reset values
	localparam logic [CYC_W-1:0] COUNT_RESET = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;

	// Memory target of a data access
	typedef enum logic [1:0] {
		TGT_NONE = 2'b00, // No memory access
		TGT_ONCHIP_EXPANSION_DATA_RAM = 2'b01, // On-chip expansion data RAM
		TGT_OFFCHIP = 2'b10, // External memory interface
		TGT_FLASH = 2'b11 // Program flash
	} cit_target_type;

	// Debug run state
	typedef enum logic [1:0] {
		DBG_RUN = 2'b00, // Free running
		DBG_HALTED = 2'b01, // Stopped, no issue
		DBG_STEP = 2'b10 // One instruction then stop
	} cit_dbg_state_type;

	// Decoded timing of one opcode
	typedef struct packed {
		logic [LEN_W-1:0] len; // Program bytes
		logic [CYC_W-1:0] cyc; // Clocks when no branch is taken
		logic cond; // Conditional branch: one clock more if taken
	} cit_decode_type;

	// Cycle counter state
	typedef struct packed {
		logic [CYC_W-1:0] remaining; // Clocks left of the running instruction
	} cit_count_state_type;

	// Decoder state
	typedef struct packed {
		cit_dbg_state_type dbg; // Debug run state
		logic resume_skip; // Ignore breakpoint for first issue after resume
		logic wpt_pending; // Watchpoint hit, halt at retire
		logic [LEN_W-1:0] bytes; // Length of current instruction
		logic [CYC_W-1:0] cycles; // Clock count of current instruction
		logic mem_req; // Memory request pulse
		logic mem_write; // Memory request is a write
		cit_target_type target; // Memory target
		logic [ADDR_W-1:0] addr; // Memory address
		logic bkpt_hit; // Breakpoint stopped the core
	} cit_state_type;

endpackage : cit_pkg

// ===== cit_cycle_counter.sv
/*
 * Down counter that times one instruction in whole system clocks.
 * Assumes load is only raised while ready_o is high.
 */
`timescale 1ns/1ps
`default_nettype none

module cit_cycle_counter #(
	parameter int CYC_W = cit_pkg::CYC_W // Counter width
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic load_i,
	input wire logic [CYC_W-1:0] value_i,
	output logic [CYC_W-1:0] remaining_o,
	output logic last_o,
	output logic ready_o
);

	cit_pkg::cit_count_state_type state_reg; // Registered state
	cit_pkg::cit_count_state_type state_next; // Next state

	// Load on issue, otherwise count down to zero
	always_comb begin
		state_next = state_reg;
		if (load_i) begin
			state_next.remaining = value_i;
		end else if (state_reg.remaining != '0) begin
			state_next.remaining = state_reg.remaining - 1'b1;
		end
	end

	// State register
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= '{remaining: cit_pkg::COUNT_RESET};
		end else begin
			state_reg <= state_next;
		end
	end

	// Status toward the decoder
	assign remaining_o = state_reg.remaining;
	assign last_o = (state_reg.remaining == cit_pkg::CYC_1);
	assign ready_o = (state_reg.remaining <= cit_pkg::CYC_1);

endmodule // cit_cycle_counter

`default_nettype wire

// ===== cit_decoder.sv
/*
 * Instruction timing decoder of the pipelined 8-bit core, with memory
 * target steering of the data and code moves and run control for debug.
 * Assumes opcodes, branch outcome and addresses come from the datapath
 * synchronous to clock_i, and debug commands from the test-access port.
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// RQ1 - No instruction exceeds eight clocks
// RQ2 - Up to 25 MHz, one instruction per clock
// RQ3 - Exactly 109 instructions with given timing mix
// RQ4 - Standard encoding, only timing differs
// RQ5 - Timing counted in single clocks only
// RQ6 - Most instructions: clocks equal program bytes
// RQ7 - Untaken conditional branch one clock shorter
// RQ8 - Data move reaches on-chip, off-chip, flash
// RQ9 - Flash read and written byte-wise
// RQ10 - Add and add-with-carry timing table
// RQ11 - Subtract-with-borrow timing table
// RQ12 - Logical and/or timing table
// RQ13 - Exclusive-or timing table
// RQ14 - Breakpoints, watchpoints, halt, run, single-step
// RQ15 - Debug uses no application resources
// RQ16 - Test-access port carries programming and debug
// RQ17 - Increment and decrement timing table
// RQ18 - Multiply four clocks, divide eight clocks
module cit_decoder #(
	parameter int EXPANSION_DATA_RAM_BYTES = cit_pkg::EXPANSION_DATA_RAM_BYTES // On-chip data RAM size
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	// Instruction issue
	input wire logic issue_valid_i,
	input wire logic [cit_pkg::OPCODE_W-1:0] opcode_i,
	input wire logic [cit_pkg::ADDR_W-1:0] instr_addr_i,
	input wire logic branch_taken_i,
	output logic issue_ready_o,
	output logic retire_o,
	output logic [cit_pkg::LEN_W-1:0] bytes_o,
	output logic [cit_pkg::CYC_W-1:0] cycles_o,
	// Memory access of data and code moves
	input wire logic [cit_pkg::ADDR_W-1:0] mem_addr_i,
	input wire logic flash_access_en_i,
	output logic mem_req_o,
	output logic mem_write_o,
	output cit_pkg::cit_target_type mem_target_o,
	output logic [cit_pkg::ADDR_W-1:0] mem_addr_o,
	// Debug commands from the test-access port
	input wire logic dbg_halt_i,
	input wire logic dbg_run_i,
	input wire logic dbg_step_i,
	input wire logic bkpt_en_i,
	input wire logic [cit_pkg::ADDR_W-1:0] bkpt_addr_i,
	input wire logic wpt_en_i,
	input wire logic [cit_pkg::ADDR_W-1:0] wpt_addr_i,
	output logic halted_o,
	output logic bkpt_hit_o
);

	cit_pkg::cit_state_type state_reg; // Registered state
	cit_pkg::cit_state_type state_next; // Next state
	cit_pkg::cit_decode_type dec; // Timing of the offered opcode

	logic ctr_ready; // Counter can take a new instruction
	logic ctr_last; // Last clock of the running instruction
	logic take; // Instruction taken this clock
	logic bkpt_match; // Offered address hits the breakpoint
	logic issue_allowed; // Debug state lets an instruction issue
	logic [cit_pkg::CYC_W-1:0] issue_cycles; // Clocks of the taken instruction
	logic [3:0] op_hi; // Opcode row
	logic [3:0] op_lo; // Opcode column
	logic is_data_move; // External data move opcode
	logic is_code_move; // Code byte move opcode

	// Builds one decode entry
	function automatic cit_pkg::cit_decode_type ent(
		input logic [cit_pkg::LEN_W-1:0] l,
		input logic [cit_pkg::CYC_W-1:0] c,
		input logic b
	);
		cit_pkg::cit_decode_type e;
		e.len = l;
		e.cyc = c;
		e.cond = b;
		return e;
	endfunction

	// Opcode to length and clocks, standard encoding by row and column
	always_comb begin
		op_hi = opcode_i[7:4];
		op_lo = opcode_i[3:0];
		dec = ent(cit_pkg::LEN_1, cit_pkg::CYC_1, 1'b0); // RQ3 RQ4 RQ5
		if (op_lo[3]) begin
			// Register forms: add, subtract, logic, inc, dec take one clock
			case (op_hi)
				4'h7, 4'h8, 4'hA: begin
					dec = ent(cit_pkg::LEN_2, cit_pkg::CYC_2, 1'b0); // RQ6
				end
				4'hB: begin
					dec = ent(cit_pkg::LEN_3, cit_pkg::CYC_3, 1'b1); // RQ7
				end
				4'hD: begin
					dec = ent(cit_pkg::LEN_2, cit_pkg::CYC_2, 1'b1); // RQ7
				end
				default: begin
					dec = ent(cit_pkg::LEN_1, cit_pkg::CYC_1, 1'b0); // RQ10 RQ11 RQ12 RQ13 RQ17
				end
			endcase
		end else begin
			case (op_lo)
				4'h0: begin
					case (op_hi)
						4'h0: dec = ent(cit_pkg::LEN_1, cit_pkg::CYC_1, 1'b0);
						// Bit test jumps
						4'h1, 4'h2, 4'h3: dec = ent(cit_pkg::LEN_3, cit_pkg::CYC_3, 1'b1); // RQ7
						// Carry and accumulator jumps
						4'h4, 4'h5, 4'h6, 4'h7: dec = ent(cit_pkg::LEN_2, cit_pkg::CYC_2, 1'b1); // RQ7
						// Short jump
						4'h8: dec = ent(cit_pkg::LEN_2, cit_pkg::CYC_3, 1'b0);
						// Data pointer load
						4'h9: dec = ent(cit_pkg::LEN_3, cit_pkg::CYC_3, 1'b0);
						// Carry logic, push, pop
						4'hA, 4'hB, 4'hC, 4'hD: dec = ent(cit_pkg::LEN_2, cit_pkg::CYC_2, 1'b0);
						// Data move through the data pointer
						default: dec = ent(cit_pkg::LEN_1, cit_pkg::CYC_3, 1'b0); // RQ8
					endcase
				end
				4'h1: begin
					// Absolute jump and call
					dec = ent(cit_pkg::LEN_2, cit_pkg::CYC_3, 1'b0);
				end
				4'h2: begin
					case (op_hi)
						// Long jump and call
						4'h0, 4'h1: dec = ent(cit_pkg::LEN_3, cit_pkg::CYC_4, 1'b0);
						// Returns
						4'h2, 4'h3: dec = ent(cit_pkg::LEN_1, cit_pkg::CYC_5, 1'b0);
						// Data move through R0
						4'hE, 4'hF: dec = ent(cit_pkg::LEN_1, cit_pkg::CYC_3, 1'b0); // RQ8
						// Accumulator into direct byte, bit operations
						default: dec = ent(cit_pkg::LEN_2, cit_pkg::CYC_2, 1'b0); // RQ12
					endcase
				end
				4'h3: begin
					case (op_hi)
						// Immediate into direct byte
						4'h4, 4'h5, 4'h6: dec = ent(cit_pkg::LEN_3, cit_pkg::CYC_3, 1'b0); // RQ12
						// Indirect jump and code byte moves
						4'h7, 4'h8, 4'h9: dec = ent(cit_pkg::LEN_1, cit_pkg::CYC_3, 1'b0); // RQ9
						// Data move through R1
						4'hE, 4'hF: dec = ent(cit_pkg::LEN_1, cit_pkg::CYC_3, 1'b0); // RQ8
						// Rotates, pointer increment, carry operations
						default: dec = ent(cit_pkg::LEN_1, cit_pkg::CYC_1, 1'b0); // RQ17
					endcase
				end
				4'h4: begin
					case (op_hi)
						// Accumulator inc, dec, swap, adjust, clear, complement
						4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: begin
							dec = ent(cit_pkg::LEN_1, cit_pkg::CYC_1, 1'b0); // RQ17
						end
						// Divide, the only eight clock instruction
						4'h8: dec = ent(cit_pkg::LEN_1, cit_pkg::CYC_MAX, 1'b0); // RQ1 RQ18
						// Multiply
						4'hA: dec = ent(cit_pkg::LEN_1, cit_pkg::CYC_4, 1'b0); // RQ18
						// Compare immediate and jump
						4'hB: dec = ent(cit_pkg::LEN_3, cit_pkg::CYC_3, 1'b1); // RQ7
						// Immediate into accumulator
						default: dec = ent(cit_pkg::LEN_2, cit_pkg::CYC_2, 1'b0); // RQ10 RQ11 RQ12
					endcase
				end
				4'h5: begin
					case (op_hi)
						// Immediate or direct into direct byte
						4'h7, 4'h8: dec = ent(cit_pkg::LEN_3, cit_pkg::CYC_3, 1'b0);
						// Unused opcode behaves as one byte, one clock
						4'hA: dec = ent(cit_pkg::LEN_1, cit_pkg::CYC_1, 1'b0);
						// Compare direct and decrement-jump on direct
						4'hB, 4'hD: dec = ent(cit_pkg::LEN_3, cit_pkg::CYC_3, 1'b1); // RQ7
						// Direct forms
						default: dec = ent(cit_pkg::LEN_2, cit_pkg::CYC_2, 1'b0); // RQ10 RQ11 RQ13
					endcase
				end
				default: begin
					// Indirect forms through R0 or R1
					case (op_hi)
						4'h7, 4'h8, 4'hA: dec = ent(cit_pkg::LEN_2, cit_pkg::CYC_2, 1'b0);
						// Compare indirect and jump
						4'hB: dec = ent(cit_pkg::LEN_3, cit_pkg::CYC_4, 1'b1); // RQ7
						// One byte, two clocks
						default: dec = ent(cit_pkg::LEN_1, cit_pkg::CYC_2, 1'b0); // RQ10 RQ11 RQ12 RQ13
					endcase
				end
			endcase
		end
	end

	// Opcode classes that touch memory outside the register file
	assign is_data_move = (op_hi >= 4'hE) &&
		((op_lo == 4'h0) || (op_lo == 4'h2) || (op_lo == 4'h3)); // RQ8
	assign is_code_move = (op_lo == 4'h3) && ((op_hi == 4'h8) || (op_hi == 4'h9)); // RQ9

	// Taken branch adds one clock, the table keeps all within eight
	assign issue_cycles = dec.cyc + {3'h0, dec.cond & branch_taken_i}; // RQ7 RQ1

	// Breakpoint compare uses dedicated registers outside the user map
	assign bkpt_match = bkpt_en_i && (instr_addr_i == bkpt_addr_i); // RQ14 RQ15

	// Issue permission from the debug state
	always_comb begin
		case (state_reg.dbg)
			cit_pkg::DBG_RUN: begin
				issue_allowed = !state_reg.wpt_pending &&
					(!bkpt_match || state_reg.resume_skip); // RQ14
			end
			cit_pkg::DBG_STEP: begin
				issue_allowed = 1'b1; // RQ14
			end
			default: begin
				issue_allowed = 1'b0;
			end
		endcase
	end

	// One instruction per clock when the previous one is ending
	assign issue_ready_o = ctr_ready && issue_allowed; // RQ2
	assign take = issue_valid_i && issue_ready_o;

	// Next state: debug control, decode capture and memory steering
	always_comb begin
		state_next = state_reg;
		state_next.mem_req = 1'b0;
		case (state_reg.dbg)
			cit_pkg::DBG_RUN: begin
				if (take) begin
					state_next.resume_skip = 1'b0;
				end
				if (dbg_halt_i) begin
					// Running instruction completes, no further issue
					state_next.dbg = cit_pkg::DBG_HALTED; // RQ14 RQ16
				end else if (issue_valid_i && ctr_ready && bkpt_match &&
						!state_reg.resume_skip && !state_reg.wpt_pending) begin
					// Stop before the instruction at the breakpoint
					state_next.dbg = cit_pkg::DBG_HALTED; // RQ14
					state_next.bkpt_hit = 1'b1;
				end else if (state_reg.wpt_pending && ctr_ready) begin
					// Stop after the access that hit the watchpoint
					state_next.dbg = cit_pkg::DBG_HALTED; // RQ14
					state_next.wpt_pending = 1'b0;
				end
			end
			cit_pkg::DBG_HALTED: begin
				if (dbg_step_i) begin
					state_next.dbg = cit_pkg::DBG_STEP; // RQ14 RQ16
					state_next.bkpt_hit = 1'b0;
				end else if (dbg_run_i) begin
					state_next.dbg = cit_pkg::DBG_RUN; // RQ14 RQ16
					state_next.resume_skip = 1'b1;
					state_next.bkpt_hit = 1'b0;
				end
			end
			cit_pkg::DBG_STEP: begin
				// Any instruction steps, one at the breakpoint address included
				if (take) begin
					state_next.dbg = cit_pkg::DBG_HALTED; // RQ14
				end
			end
			default: begin
				state_next.dbg = cit_pkg::DBG_HALTED;
			end
		endcase
		if (take) begin
			state_next.bytes = dec.len;
			state_next.cycles = issue_cycles;
			state_next.target = cit_pkg::TGT_NONE;
			state_next.mem_write = 1'b0;
			state_next.addr = mem_addr_i;
			if (is_data_move) begin
				// Flash when enabled, else on-chip below the size, else off-chip
				state_next.mem_req = 1'b1;
				state_next.mem_write = op_hi[0]; // RQ9
				if (flash_access_en_i) begin
					state_next.target = cit_pkg::TGT_FLASH; // RQ8 RQ9
				end else if (32'(mem_addr_i) < EXPANSION_DATA_RAM_BYTES) begin
					state_next.target = cit_pkg::TGT_ONCHIP_EXPANSION_DATA_RAM; // RQ8
				end else begin
					state_next.target = cit_pkg::TGT_OFFCHIP; // RQ8
				end
				if (wpt_en_i && (mem_addr_i == wpt_addr_i)) begin
					state_next.wpt_pending = 1'b1; // RQ14
				end
			end else if (is_code_move) begin
				// Byte read of program flash
				state_next.mem_req = 1'b1;
				state_next.target = cit_pkg::TGT_FLASH; // RQ9
			end
		end
	end

	// Instruction clock counter
	cit_cycle_counter #(
		.CYC_W(cit_pkg::CYC_W)
	) u_counter (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.load_i(take),
		.value_i(issue_cycles),
		.remaining_o(),
		.last_o(ctr_last),
		.ready_o(ctr_ready)
	);

	// State register
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg.dbg <= cit_pkg::DBG_RUN;
			state_reg.resume_skip <= 1'b0;
			state_reg.wpt_pending <= 1'b0;
			state_reg.bytes <= '0;
			state_reg.cycles <= cit_pkg::COUNT_RESET;
			state_reg.mem_req <= 1'b0;
			state_reg.mem_write <= 1'b0;
			state_reg.target <= cit_pkg::TGT_NONE;
			state_reg.addr <= cit_pkg::ADDR_RESET;
			state_reg.bkpt_hit <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs
	assign retire_o = ctr_last;
	assign bytes_o = state_reg.bytes;
	assign cycles_o = state_reg.cycles;
	assign mem_req_o = state_reg.mem_req;
	assign mem_write_o = state_reg.mem_write;
	assign mem_target_o = state_reg.target;
	assign mem_addr_o = state_reg.addr;
	assign halted_o = (state_reg.dbg == cit_pkg::DBG_HALTED);
	assign bkpt_hit_o = state_reg.bkpt_hit;

endmodule // cit_decoder

`default_nettype wire

// ===== cit_decoder_sva.sv
/*
 * Timing checker of the instruction timing decoder: take, retire, refusal
 * and memory move steering.
 * Assumes it is bound to the decoder and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module cit_decoder_sva (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic issue_valid_i,
	input wire logic [cit_pkg::OPCODE_W-1:0] opcode_i,
	input wire logic branch_taken_i,
	input wire logic issue_ready_o,
	input wire logic retire_o,
	input wire logic [cit_pkg::CYC_W-1:0] cycles_o,
	input wire logic [cit_pkg::ADDR_W-1:0] mem_addr_i,
	input wire logic flash_access_en_i,
	input wire logic mem_req_o,
	input wire logic mem_write_o,
	input wire cit_pkg::cit_target_type mem_target_o
);
	// One clock domain for every check
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	// An opcode is taken at this edge
	logic take;
	assign take = issue_valid_i && issue_ready_o;

	a_retire_bound: assert property (take |-> ##[1:8] retire_o)
		else $error("instruction ran past eight clocks");
	a_single_clock: assert property (take ##1 cycles_o == 4'h1 |-> retire_o)
		else $error("one clock instruction did not retire");
	a_busy_refuse: assert property (take ##1 cycles_o > 4'h1 |-> !issue_ready_o && !retire_o)
		else $error("issue accepted while busy");
	a_cycle_ceiling: assert property (cycles_o <= 4'h8)
		else $error("cycle count above eight");
	a_divide_eight: assert property (take && opcode_i == 8'h84 |=> cycles_o == 4'h8 ##7 retire_o)
		else $error("divide not eight clocks");
	a_multiply_four: assert property (take && opcode_i == 8'hA4 |=> cycles_o == 4'h4 ##3 retire_o)
		else $error("multiply not four clocks");
	a_branch_extra: assert property (take && opcode_i inside {8'h60, 8'h70}
		|=> cycles_o == 4'h2 + {3'h0, $past(branch_taken_i)})
		else $error("branch timing wrong");
	a_move_pulse: assert property (take && opcode_i inside {8'hE0, 8'hF0, 8'h93}
		|=> mem_req_o ##1 !mem_req_o)
		else $error("move request not one pulse");
	a_flash_write: assert property (take && opcode_i == 8'hF0 && flash_access_en_i
		|=> mem_write_o && mem_target_o == cit_pkg::TGT_FLASH)
		else $error("flash byte write not steered");
	a_onchip_target: assert property (take && opcode_i == 8'hE0 && !flash_access_en_i
		&& mem_addr_i < 16'(cit_pkg::EXPANSION_DATA_RAM_BYTES) |=> mem_target_o == cit_pkg::TGT_ONCHIP_EXPANSION_DATA_RAM)
		else $error("on-chip data move not steered");
endmodule // cit_decoder_sva

bind cit_decoder cit_decoder_sva cit_decoder_sva_i (.clock_i, .resetn_i, .issue_valid_i,
	.opcode_i, .branch_taken_i, .issue_ready_o, .retire_o, .cycles_o, .mem_addr_i,
	.flash_access_en_i, .mem_req_o, .mem_write_o, .mem_target_o);

`default_nettype wire

// ===== cit_mem_model.sv
/*
 * Behavioural program flash and request counter fed by the decoder's moves.
 * Assumes requests come as one-clock pulses with target and address steady.
 */
`timescale 1ns/1ps
`default_nettype none

module cit_mem_model (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic mem_req_i,
	input wire logic mem_write_i,
	input wire cit_pkg::cit_target_type mem_target_i,
	input wire logic [cit_pkg::ADDR_W-1:0] mem_addr_i,
	output var int req_count_o,
	output var int flash_writes_o
);
	// Program flash, one byte per address
	logic [7:0] flash_mem [0:255];

	// Counts requests and stores flash bytes one at a time
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			req_count_o <= 0;
			flash_writes_o <= 0;
		end else if (mem_req_i) begin
			req_count_o <= req_count_o + 1;
			// Only a write aimed at flash changes program memory
			if (mem_write_i && mem_target_i == cit_pkg::TGT_FLASH) begin
				flash_mem[mem_addr_i[7:0]] <= mem_addr_i[15:8];
				flash_writes_o <= flash_writes_o + 1;
			end
		end
	end
endmodule // cit_mem_model

`default_nettype wire

// ===== tb_top.sv
/*
 * Self-checking bench of the instruction timing decoder.
 * Assumes take on valid and ready, retire in the last clock of an opcode.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic clock_i, resetn_i, issue_valid_i, branch_taken_i, flash_access_en_i;
	logic dbg_halt_i, dbg_run_i, dbg_step_i, bkpt_en_i, wpt_en_i;
	logic issue_ready_o, retire_o, mem_req_o, mem_write_o, halted_o, bkpt_hit_o;
	logic [7:0] opcode_i;
	logic [15:0] instr_addr_i, mem_addr_i, bkpt_addr_i, wpt_addr_i, mem_addr_o;
	logic [1:0] bytes_o;
	logic [3:0] cycles_o;
	cit_pkg::cit_target_type mem_target_o;
	int req_count, flash_writes, miscompares, check_count, seed, mem_ops, n, fl_wr;
	// Opcode, bytes, clocks of every form under test
	logic [15:0] tbl [40] = '{16'h2811, 16'h2522, 16'h2612, 16'h2422, 16'h3522,
		16'h3712, 16'h3811, 16'h3422, 16'h9811, 16'h9522, 16'h9612, 16'h9422,
		16'h0411, 16'h0811, 16'h0522, 16'h1612, 16'hA311, 16'h5811, 16'h5522,
		16'h5612, 16'h5422, 16'h5222, 16'h5333, 16'h4811, 16'h4522, 16'h4612,
		16'h4422, 16'h4222, 16'h4333, 16'h6811, 16'h6522, 16'h6612, 16'hA414,
		16'h8418, 16'hD411, 16'h0011, 16'h6022, 16'h7022, 16'hE013, 16'hF013};

	cit_decoder cit_decoder_i (.clock_i, .resetn_i, .issue_valid_i, .opcode_i, .instr_addr_i,
		.branch_taken_i, .issue_ready_o, .retire_o, .bytes_o, .cycles_o, .mem_addr_i,
		.flash_access_en_i, .mem_req_o, .mem_write_o, .mem_target_o, .mem_addr_o,
		.dbg_halt_i, .dbg_run_i, .dbg_step_i, .bkpt_en_i, .bkpt_addr_i, .wpt_en_i,
		.wpt_addr_i, .halted_o, .bkpt_hit_o);
	cit_mem_model cit_mem_model_i (.clock_i, .resetn_i, .mem_req_i(mem_req_o),
		.mem_write_i(mem_write_o), .mem_target_i(mem_target_o), .mem_addr_i(mem_addr_o),
		.req_count_o(req_count), .flash_writes_o(flash_writes));

	// Counts one comparison and reports a difference
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Target a move must reach
	function automatic logic [1:0] exp_tgt(input logic [7:0] op, input logic fl,
		input logic [15:0] a);
		if (op == 8'h93 || fl)
			return 2'h3;
		return (a < 16'(cit_pkg::EXPANSION_DATA_RAM_BYTES)) ? 2'h1 : 2'h2;
	endfunction

	// Offers one opcode after a rising edge and times it to retire
	task automatic run_op(input logic [15:0] e, input logic tk, input logic fl,
		input logic [15:0] a);
		int x;
		issue_valid_i <= 1'b1;
		opcode_i <= e[15:8];
		branch_taken_i <= tk;
		flash_access_en_i <= fl;
		mem_addr_i <= a;
		instr_addr_i <= 16'($random(seed));
		repeat (50) begin
			@(negedge clock_i);
			if (issue_ready_o === 1'b1)
				break;
		end
		@(posedge clock_i);
		issue_valid_i <= 1'b0;
		n = 0;
		repeat (9) begin
			@(negedge clock_i);
			n++;
			if (retire_o === 1'b1)
				break;
		end
		x = e[3:0] + ((e[15:8] inside {8'h60, 8'h70}) ? int'(tk) : 0);
		chk(16'(n), 16'(x), "clocks to retire");
		chk(16'(cycles_o), 16'(x), "cycle count");
		chk(16'(bytes_o), 16'(e[7:4]), "byte count");
		// Moves also check steering
		if (e[15:8] inside {8'hE0, 8'hF0, 8'h93}) begin
			mem_ops++;
			fl_wr += int'(e[15:8] == 8'hF0 && fl);
			chk(16'(mem_target_o), 16'(exp_tgt(e[15:8], fl, a)), "move target");
			chk(16'(mem_write_o), 16'(e[15:8] == 8'hF0), "move direction");
			chk(mem_addr_o, a, "move address");
		end
		@(posedge clock_i);
	endtask

	// Counts retires over a number of clocks
	task automatic count_retire(input int cyc);
		n = 0;
		repeat (cyc) begin
			@(negedge clock_i);
			if (retire_o === 1'b1)
				n++;
		end
	endtask

	// One clock of a debug command: halt, run, step
	task automatic dbg_pulse(input logic [2:0] hrs);
		@(posedge clock_i);
		{dbg_halt_i, dbg_run_i, dbg_step_i} <= hrs;
		@(posedge clock_i);
		{dbg_halt_i, dbg_run_i, dbg_step_i} <= 3'b000;
	endtask

	// Prints the counts and the verdict, then ends the run
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Free running system clock
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	// Cuts a hang short
	initial begin
		#(50 * 20000);
		miscompares++;
		print_verdict;
	end

	// Main sequence
	initial begin
		seed = 56;
		{resetn_i, issue_valid_i, branch_taken_i, flash_access_en_i} = 4'h0;
		{dbg_halt_i, dbg_run_i, dbg_step_i, bkpt_en_i, wpt_en_i} = 5'h00;
		opcode_i = 8'h00;
		{instr_addr_i, mem_addr_i, bkpt_addr_i, wpt_addr_i} = 64'h0;
		repeat (16) @(posedge clock_i);
		resetn_i <= 1'b1;
		@(posedge clock_i);
		foreach (tbl[i]) run_op(tbl[i], 1'b0, 1'b0, 16'h0FFF);
		run_op(16'h6022, 1'b1, 1'b0, 16'h1000);
		run_op(16'h7022, 1'b1, 1'b0, 16'h1000);
		run_op(16'h9313, 1'b0, 1'b0, 16'h0040);
		run_op(16'hF013, 1'b0, 1'b1, 16'h0041);
		$display("table test done");
		repeat (200) run_op(tbl[$unsigned($random(seed)) % 40], 1'($random(seed)),
			1'($random(seed)), 16'($random(seed)));
		$display("random test done");
		// Back to back one clock opcodes
		opcode_i <= 8'h00;
		issue_valid_i <= 1'b1;
		@(posedge clock_i);
		count_retire(8);
		chk(16'(n), 16'h0008, "retires per clock");
		@(posedge clock_i);
		issue_valid_i <= 1'b0;
		@(posedge clock_i);
		// Breakpoint stops before issue, run passes it once
		bkpt_en_i <= 1'b1;
		bkpt_addr_i <= 16'h0200;
		instr_addr_i <= 16'h0200;
		issue_valid_i <= 1'b1;
		count_retire(4);
		chk(16'(n), 16'h0000, "retire past breakpoint");
		chk(16'(bkpt_hit_o), 16'h0001, "breakpoint flag");
		dbg_pulse(3'b010);
		count_retire(5);
		chk(16'(n), 16'h0001, "one issue after resume");
		chk(16'(halted_o), 16'h0001, "halt on breakpoint again");
		@(posedge clock_i);
		bkpt_en_i <= 1'b0;
		dbg_pulse(3'b010);
		// Halt lets the running opcode end, step issues exactly one
		dbg_pulse(3'b100);
		count_retire(1);
		count_retire(5);
		chk(16'(n), 16'h0000, "retire while halted");
		dbg_pulse(3'b001);
		count_retire(6);
		chk(16'(n), 16'h0001, "single step");
		chk(16'(halted_o), 16'h0001, "halted after step");
		@(posedge clock_i);
		issue_valid_i <= 1'b0;
		dbg_pulse(3'b010);
		// Watchpoint halts after the matching move
		wpt_en_i <= 1'b1;
		wpt_addr_i <= 16'h0300;
		run_op(16'hE013, 1'b0, 1'b0, 16'h0300);
		@(negedge clock_i);
		chk(16'(halted_o), 16'h0001, "watchpoint halt");
		@(posedge clock_i);
		wpt_en_i <= 1'b0;
		dbg_pulse(3'b010);
		repeat (2) @(posedge clock_i);
		chk(16'(req_count), 16'(mem_ops), "memory requests");
		chk(16'(flash_writes), 16'(fl_wr), "flash byte writes");
		$display("debug test done");
		print_verdict;
	end
endmodule // tb_top

`default_nettype wire
